// ---- srda_core.sv ----
// serial port memory access: link side shift logic and core side cell array
`timescale 1ns/100ps
module srda_core #(
   parameter int FLOAT_CYC = srda_pkg::cyc_of(srda_pkg::T_FLOAT_NS),
   parameter int ENA_CYC   = srda_pkg::cyc_of(srda_pkg::T_ENABLE_NS),
   parameter int LOW_CYC   = srda_pkg::cyc_of(srda_pkg::T_FORCE_LOW_NS),
   parameter int REL_CYC   = srda_pkg::cyc_of(srda_pkg::T_RELEASE_NS)
) (
   input  wire logic                       CLK_I,
   input  wire logic                       RST_I,
   input  wire logic                       LINK_CLK_I,
   input  wire logic                       CHIP_ENABLE_N_I,
   input  wire logic                       CHIP_SELECT_I,
   input  wire logic [srda_pkg::ADDR_W-1:0] CELL_ADDRESS_I,
   input  wire logic                       WRITE_ENABLE_N_I,
   input  wire logic                       WRITE_STROBE_N_I,
   input  wire logic                       READ_STROBE_N_I,
   input  wire logic                       SHIFT_IN_CLOCK_I,
   input  wire logic                       SHIFT_OUT_CLOCK_I,
   input  wire logic                       OUTPUT_ENABLE_N_I,
   input  wire logic                       OUTPUT_FORCE_CONTROL_I,
   input  wire logic                       PORT_DIRECTION_SELECT_I,
   input  wire logic [7:0]                 BYTE_PORT_FIRST_I,
   output logic      [7:0]                 BYTE_PORT_FIRST_O,
   output logic                            BYTE_PORT_FIRST_OE_O,
   input  wire logic [7:0]                 BYTE_PORT_SECOND_I,
   output logic      [7:0]                 BYTE_PORT_SECOND_O,
   output logic                            BYTE_PORT_SECOND_OE_O
);
   // ----------------------------------------------------------------
   // link reset: RST_I brought into the link domain
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_l_reg;

   always_ff @(posedge LINK_CLK_I) begin
      rst_meta_reg <= RST_I;
      rst_l_reg    <= rst_meta_reg;
   end

   // ----------------------------------------------------------------
   // link side: edges and address decode
   // ----------------------------------------------------------------
   // host pins are logic on the link clock, so they are read directly;
   // the shift clocks must run no faster than half the link clock
   logic                          ce_prev_reg, sic_prev_reg, soc_prev_reg;
   logic                          rs_prev_reg, ws_prev_reg;
   logic                          ce_fall, sic_rise, soc_rise, rs_fall, ws_fall;
   logic [srda_pkg::ROW_W-1:0]    row, col;
   logic                          addr_ok;
   logic [srda_pkg::IDX_W-1:0]    idx;
   logic [srda_pkg::BYTE_W-1:0]   in_byte;

   assign ce_fall  = ce_prev_reg & ~CHIP_ENABLE_N_I;
   assign sic_rise = ~sic_prev_reg & SHIFT_IN_CLOCK_I;
   assign soc_rise = ~soc_prev_reg & SHIFT_OUT_CLOCK_I;
   assign rs_fall  = rs_prev_reg & ~READ_STROBE_N_I;
   assign ws_fall  = ws_prev_reg & ~WRITE_STROBE_N_I;
   assign row      = CELL_ADDRESS_I[srda_pkg::ROW_LO +: srda_pkg::ROW_W];
   assign col      = CELL_ADDRESS_I[srda_pkg::COL_LO +: srda_pkg::ROW_W];
   assign addr_ok  = (row < srda_pkg::ROWS) && (col < srda_pkg::COLS);
   assign idx      = srda_pkg::IDX_W'(col * srda_pkg::ROWS + row);
   assign in_byte  = PORT_DIRECTION_SELECT_I ? BYTE_PORT_FIRST_I : BYTE_PORT_SECOND_I;

   always_ff @(posedge LINK_CLK_I) begin
      if (rst_l_reg) begin
         ce_prev_reg  <= 1'b1;
         sic_prev_reg <= 1'b0;
         soc_prev_reg <= 1'b0;
         rs_prev_reg  <= 1'b1;
         ws_prev_reg  <= 1'b1;
      end else begin
         ce_prev_reg  <= CHIP_ENABLE_N_I;
         sic_prev_reg <= SHIFT_IN_CLOCK_I;
         soc_prev_reg <= SHIFT_OUT_CLOCK_I;
         rs_prev_reg  <= READ_STROBE_N_I;
         ws_prev_reg  <= WRITE_STROBE_N_I;
      end
   end

   // ----------------------------------------------------------------
   // link side: access cycle, shift registers and latch
   // ----------------------------------------------------------------
   srda_pkg::srda_cyc_t          state_reg, state_next;
   srda_pkg::srda_req_t          req_reg, req_next;
   logic                         tog_reg, tog_next;
   logic                         we_seen_reg, we_seen_next;
   logic [srda_pkg::ADDR_W-1:0]  addr_reg, addr_next;
   logic                         sel_reg, sel_next;
   logic [srda_pkg::WORD_W-1:0]  rd_word_reg, rd_word_next;
   logic [srda_pkg::WORD_W-1:0]  io_reg, io_next;
   logic [srda_pkg::WORD_W-1:0]  sin_reg, sin_next;
   logic [srda_pkg::WORD_W-1:0]  sout_reg, sout_next;
   logic [srda_pkg::BYTE_W-1:0]  out_reg, out_next;
   logic                         ack_meta_reg, ack_sync_reg, ack_seen_reg;
   logic                         ack_evt;
   logic                         ack_tog_reg;
   logic [srda_pkg::WORD_W-1:0]  rdata_reg;

   assign ack_evt = ack_sync_reg ^ ack_seen_reg;

   always_comb begin
      state_next   = state_reg;
      req_next     = req_reg;
      tog_next     = tog_reg;
      we_seen_next = we_seen_reg;
      addr_next    = addr_reg;
      sel_next     = sel_reg;
      rd_word_next = rd_word_reg;
      io_next      = io_reg;
      sin_next     = sin_reg;
      sout_next    = sout_reg;
      out_next     = out_reg;
      if (sic_rise)
         sin_next = {sin_reg[srda_pkg::WORD_W-srda_pkg::BYTE_W-1:0], in_byte};
      if (ws_fall)
         io_next = sin_reg;
      if (rs_fall) begin
         io_next   = rd_word_reg;
         sout_next = rd_word_reg;
      end else if (soc_rise) begin
         // zero fill: bytes past the eighth carry no data
         out_next  = sout_reg[srda_pkg::WORD_W-1 -: srda_pkg::BYTE_W];
         sout_next = {sout_reg[srda_pkg::WORD_W-srda_pkg::BYTE_W-1:0], 8'h00};
      end
      if (ack_evt && !req_reg.write)
         rd_word_next = rdata_reg;
      case (state_reg)
         srda_pkg::SRDA_IDLE: begin
            we_seen_next = 1'b0;
            if (ce_fall) begin
               addr_next = CELL_ADDRESS_I;
               sel_next  = CHIP_SELECT_I;
               if (CHIP_SELECT_I && addr_ok) begin
                  req_next.idx = idx;
                  if (WRITE_ENABLE_N_I) begin
                     req_next.write = 1'b0;
                     tog_next       = ~tog_reg;
                     state_next     = srda_pkg::SRDA_READ;
                  end else begin
                     we_seen_next = 1'b1;
                     state_next   = srda_pkg::SRDA_OPEN;
                  end
               end
            end
         end
         srda_pkg::SRDA_READ: begin
            if (!WRITE_ENABLE_N_I)
               we_seen_next = 1'b1;
            if (ack_evt)
               state_next = srda_pkg::SRDA_OPEN;
         end
         srda_pkg::SRDA_OPEN: begin
            if (!WRITE_ENABLE_N_I)
               we_seen_next = 1'b1;
            if (CHIP_ENABLE_N_I) begin
               if (we_seen_reg || !WRITE_ENABLE_N_I) begin
                  // latch contents are committed as the cycle closes
                  req_next.write = 1'b1;
                  req_next.data  = io_reg;
                  tog_next       = ~tog_reg;
                  state_next     = srda_pkg::SRDA_WRITE;
               end else begin
                  state_next = srda_pkg::SRDA_IDLE;
               end
            end
         end
         srda_pkg::SRDA_WRITE: begin
            if (ack_evt)
               state_next = srda_pkg::SRDA_IDLE;
         end
         default: state_next = srda_pkg::SRDA_IDLE;
      endcase
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (rst_l_reg) begin
         state_reg    <= srda_pkg::SRDA_IDLE;
         req_reg      <= '0;
         tog_reg      <= 1'b0;
         we_seen_reg  <= 1'b0;
         addr_reg     <= '0;
         sel_reg      <= 1'b0;
         rd_word_reg  <= '0;
         io_reg       <= '0;
         sin_reg      <= '0;
         sout_reg     <= '0;
         out_reg      <= '0;
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         req_reg      <= req_next;
         tog_reg      <= tog_next;
         we_seen_reg  <= we_seen_next;
         addr_reg     <= addr_next;
         sel_reg      <= sel_next;
         rd_word_reg  <= rd_word_next;
         io_reg       <= io_next;
         sin_reg      <= sin_next;
         sout_reg     <= sout_next;
         out_reg      <= out_next;
         ack_meta_reg <= ack_tog_reg;
         ack_sync_reg <= ack_meta_reg;
         ack_seen_reg <= ack_sync_reg;
      end
   end

   // ----------------------------------------------------------------
   // link side: output gating with settle delays
   // ----------------------------------------------------------------
   srda_pkg::srda_drv_t          target, mode_reg, mode_next, pend_reg, pend_next;
   logic [srda_pkg::CNT_W-1:0]   cnt_reg, cnt_next, dly;
   logic [srda_pkg::BYTE_W-1:0]  drv_reg, drv_next;

   always_comb begin
      target = OUTPUT_ENABLE_N_I      ? srda_pkg::SRDA_FLOAT :
               OUTPUT_FORCE_CONTROL_I ? srda_pkg::SRDA_LOW : srda_pkg::SRDA_DATA;
      if (target == srda_pkg::SRDA_FLOAT)
         dly = srda_pkg::CNT_W'(FLOAT_CYC);
      else if (target == srda_pkg::SRDA_LOW)
         dly = srda_pkg::CNT_W'(mode_reg == srda_pkg::SRDA_FLOAT ? ENA_CYC : LOW_CYC);
      else
         dly = srda_pkg::CNT_W'(mode_reg == srda_pkg::SRDA_FLOAT ? ENA_CYC : REL_CYC);
      pend_next = pend_reg;
      cnt_next  = cnt_reg;
      mode_next = mode_reg;
      if (target != pend_reg) begin
         pend_next = target;
         cnt_next  = dly;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end else begin
         mode_next = pend_reg;
      end
      drv_next = (mode_next == srda_pkg::SRDA_LOW) ? 8'h00 : out_next;
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (rst_l_reg) begin
         mode_reg <= srda_pkg::SRDA_FLOAT;
         pend_reg <= srda_pkg::SRDA_FLOAT;
         cnt_reg  <= '0;
         drv_reg  <= '0;
      end else begin
         mode_reg <= mode_next;
         pend_reg <= pend_next;
         cnt_reg  <= cnt_next;
         drv_reg  <= drv_next;
      end
   end

   assign BYTE_PORT_FIRST_O     = drv_reg;
   assign BYTE_PORT_SECOND_O    = drv_reg;
   assign BYTE_PORT_FIRST_OE_O  = (mode_reg != srda_pkg::SRDA_FLOAT) & ~PORT_DIRECTION_SELECT_I;
   assign BYTE_PORT_SECOND_OE_O = (mode_reg != srda_pkg::SRDA_FLOAT) & PORT_DIRECTION_SELECT_I;

   // ----------------------------------------------------------------
   // core side: cell array behind a toggle handshake
   // ----------------------------------------------------------------
   // request payload is held still while its toggle is in flight
   logic [srda_pkg::WORD_W-1:0] mem [srda_pkg::WORDS];
   logic                        req_meta_reg, req_sync_reg, req_seen_reg;
   logic                        req_evt;
   logic                        ack_tog_next;
   logic [srda_pkg::WORD_W-1:0] rdata_next;

   always_comb begin
      req_evt      = req_sync_reg ^ req_seen_reg;
      ack_tog_next = ack_tog_reg ^ req_evt;
      rdata_next   = rdata_reg;
      if (req_evt && !req_reg.write)
         rdata_next = mem[req_reg.idx];
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         req_seen_reg <= 1'b0;
         ack_tog_reg  <= 1'b0;
         rdata_reg    <= '0;
      end else begin
         req_meta_reg <= tog_reg;
         req_sync_reg <= req_meta_reg;
         req_seen_reg <= req_sync_reg;
         ack_tog_reg  <= ack_tog_next;
         rdata_reg    <= rdata_next;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_I && req_evt && req_reg.write)
         mem[req_reg.idx] <= req_reg.data;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_addr_take;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (ce_fall && state_reg == srda_pkg::SRDA_IDLE) |=>
         (addr_reg == $past(CELL_ADDRESS_I)) && (sel_reg == $past(CHIP_SELECT_I));
   endproperty
   a_addr_take: assert property (p_addr_take) else $error("address not taken at enable fall");

   property p_unsel;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (ce_fall && state_reg == srda_pkg::SRDA_IDLE && !CHIP_SELECT_I) |=>
         state_reg == srda_pkg::SRDA_IDLE && $stable(tog_reg);
   endproperty
   a_unsel: assert property (p_unsel) else $error("deselected cycle started an access");

   property p_absent;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (ce_fall && state_reg == srda_pkg::SRDA_IDLE && !addr_ok) |=>
         state_reg == srda_pkg::SRDA_IDLE && $stable(tog_reg);
   endproperty
   a_absent: assert property (p_absent) else $error("absent address accessed");

   property p_read_go;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (ce_fall && state_reg == srda_pkg::SRDA_IDLE && CHIP_SELECT_I && addr_ok && WRITE_ENABLE_N_I) |=>
         state_reg == srda_pkg::SRDA_READ && tog_reg != $past(tog_reg) && !req_reg.write;
   endproperty
   a_read_go: assert property (p_read_go) else $error("read not issued");

   property p_ws_latch;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (ws_fall && !rs_fall) |=> io_reg == $past(sin_reg);
   endproperty
   a_ws_latch: assert property (p_ws_latch) else $error("write strobe did not latch");

   property p_rs_load;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      rs_fall |=> sout_reg == $past(rd_word_reg) && io_reg == $past(rd_word_reg);
   endproperty
   a_rs_load: assert property (p_rs_load) else $error("read strobe did not load");

   property p_shift_out;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (soc_rise && !rs_fall) |=> out_reg == $past(sout_reg[63:56]) ##1 (soc_rise || $stable(out_reg));
   endproperty
   a_shift_out: assert property (p_shift_out) else $error("shift-out byte wrong");

   property p_hold_out;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      !soc_rise |=> $stable(out_reg);
   endproperty
   a_hold_out: assert property (p_hold_out) else $error("output byte changed without clock");

   property p_shift_in;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      sic_rise |=> sin_reg == {$past(sin_reg[55:0]), $past(in_byte)};
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift-in byte lost");

   property p_float;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      OUTPUT_ENABLE_N_I [*8] |-> !BYTE_PORT_FIRST_OE_O && !BYTE_PORT_SECOND_OE_O;
   endproperty
   a_float: assert property (p_float) else $error("port driven while disabled");

   property p_force_low;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (!OUTPUT_ENABLE_N_I && OUTPUT_FORCE_CONTROL_I) [*8] |->
         drv_reg == 8'h00 && (BYTE_PORT_FIRST_OE_O ^ BYTE_PORT_SECOND_OE_O);
   endproperty
   a_force_low: assert property (p_force_low) else $error("force low not driven");

   property p_dir;
      @(posedge LINK_CLK_I) disable iff (rst_l_reg)
      (mode_reg != srda_pkg::SRDA_FLOAT) |->
         BYTE_PORT_SECOND_OE_O == PORT_DIRECTION_SELECT_I && BYTE_PORT_FIRST_OE_O == !PORT_DIRECTION_SELECT_I;
   endproperty
   a_dir: assert property (p_dir) else $error("port direction wrong");

   property p_write_done;
      @(posedge CLK_I) disable iff (RST_I)
      (req_evt && req_reg.write) |=> ##[0:20] ack_sync_reg == ack_tog_reg;
   endproperty
   a_write_done: assert property (p_write_done) else $error("write not acknowledged");

   c_read:  cover property (@(posedge LINK_CLK_I) disable iff (rst_l_reg)
                            state_reg == srda_pkg::SRDA_READ ##[1:20] state_reg == srda_pkg::SRDA_OPEN);
   c_write: cover property (@(posedge LINK_CLK_I) disable iff (rst_l_reg)
                            state_reg == srda_pkg::SRDA_WRITE ##[1:20] state_reg == srda_pkg::SRDA_IDLE);
   c_data:  cover property (@(posedge LINK_CLK_I) disable iff (rst_l_reg)
                            mode_reg == srda_pkg::SRDA_DATA && soc_rise);
endmodule

// ---- srda_pkg.sv ----
// shared constants and types of the serial port memory access block
package srda_pkg;
   // ----------------------------------------------------------------
   // address space
   // ----------------------------------------------------------------
   localparam int ADDR_W  = 18;
   localparam int ROW_W   = 9;
   localparam int ROW_LO  = 0;
   localparam int COL_LO  = 9;
   localparam int ROWS    = 270;
   localparam int COLS    = 336;
   localparam int WORDS   = 90720;
   localparam int IDX_W   = 17;
   localparam int BYTE_W  = 8;
   localparam int WORD_W  = 64;
   // ----------------------------------------------------------------
   // output timing, in nanoseconds; cyc_of turns them into link clock periods
   // ----------------------------------------------------------------
   localparam int LINK_PERIOD_NS  = 30;
   localparam int T_FLOAT_NS      = 10;
   localparam int T_ENABLE_NS     = 10;
   localparam int T_FORCE_LOW_NS  = 10;
   localparam int T_RELEASE_NS    = 10;
   localparam int CNT_W           = 4;

   // longest-time figures round down, but never below one cycle
   function automatic int cyc_of(input int t_ns);
      int c;
      c = t_ns / LINK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRDA_IDLE  = 2'b00,
      SRDA_READ  = 2'b01,
      SRDA_OPEN  = 2'b10,
      SRDA_WRITE = 2'b11
   } srda_cyc_t;

   typedef enum logic [1:0] {
      SRDA_FLOAT = 2'b00,
      SRDA_LOW   = 2'b01,
      SRDA_DATA  = 2'b10
   } srda_drv_t;

   typedef struct packed {
      logic              write;
      logic [IDX_W-1:0]  idx;
      logic [WORD_W-1:0] data;
   } srda_req_t;
endpackage

// ---- srda_host.sv ----
// host side model: resolves the two byte port wires seen by the device
`timescale 1ns/100ps
module srda_host (
   input  wire logic       dir_i,
   input  wire logic [7:0] val_i,
   input  wire logic [7:0] first_o_i,
   input  wire logic [7:0] second_o_i,
   input  wire logic       first_oe_i,
   input  wire logic       second_oe_i,
   output logic      [7:0] first_lvl_o,
   output logic      [7:0] second_lvl_o
);
   // ----------------------------------------------------------------
   // wire resolution
   // ----------------------------------------------------------------
   // a released wire shows val_i on the side the host drives, else the inverse of the last level, never a stale copy
   assign first_lvl_o  = first_oe_i ? first_o_i : (dir_i ? val_i : ~first_o_i);
   assign second_lvl_o = second_oe_i ? second_o_i : (!dir_i ? val_i : ~second_o_i);
endmodule

// ---- srda_core_test.sv ----
// self-checking bench of the serial port memory access block
`timescale 1ns/100ps
module srda_core_test;
   // ----------------------------------------------------------------
   // stimulus and wiring
   // ----------------------------------------------------------------
   logic clk = 1'b0, lclk = 1'b0, rst = 1'b1;
   logic ce_n = 1'b1, cs = 1'b0, we_n = 1'b1, ws_n = 1'b1, rs_n = 1'b1;
   logic shift_in_clock = 1'b0, soc = 1'b0, oe_n = 1'b0, frc = 1'b0, dir = 1'b1;
   logic [17:0] addr = 18'h00000;
   logic [7:0] val = 8'h00;
   logic [7:0] p1_i, p2_i, p1_o, p2_o;
   logic oe1, oe2;
   int n_errors = 0, n_compared = 0;
   always #4 clk = ~clk;
   always #15 lclk = ~lclk;
   srda_core uut (.CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk), .CHIP_ENABLE_N_I(ce_n),
      .CHIP_SELECT_I(cs), .CELL_ADDRESS_I(addr), .WRITE_ENABLE_N_I(we_n), .WRITE_STROBE_N_I(ws_n),
      .READ_STROBE_N_I(rs_n), .SHIFT_IN_CLOCK_I(shift_in_clock), .SHIFT_OUT_CLOCK_I(soc), .OUTPUT_ENABLE_N_I(oe_n),
      .OUTPUT_FORCE_CONTROL_I(frc), .PORT_DIRECTION_SELECT_I(dir), .BYTE_PORT_FIRST_I(p1_i),
      .BYTE_PORT_FIRST_O(p1_o), .BYTE_PORT_FIRST_OE_O(oe1), .BYTE_PORT_SECOND_I(p2_i),
      .BYTE_PORT_SECOND_O(p2_o), .BYTE_PORT_SECOND_OE_O(oe2));
   srda_host host (.dir_i(dir), .val_i(val), .first_o_i(p1_o), .second_o_i(p2_o), .first_oe_i(oe1),
      .second_oe_i(oe2), .first_lvl_o(p1_i), .second_lvl_o(p2_i));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic lk(input int n);
      repeat (n) @(posedge lclk);
      #1;
   endtask
   task automatic results;
      $display("mismatches %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // shift eight bytes in, latch them, then one write cycle
   task automatic wr(input logic [17:0] a, input logic c, input logic [63:0] d);
      for (int i = 0; i < 8; i++) begin
         val = d[63-8*i -: 8];
         shift_in_clock = 1'b1;
         lk(1);
         shift_in_clock = 1'b0;
         lk(1);
      end
      ws_n = 1'b0;
      lk(1);
      ws_n = 1'b1;
      lk(1);
      addr = a;
      cs = c;
      ce_n = 1'b0;
      we_n = 1'b0;
      lk(1);
      addr = ~a; // late address change must not matter
      lk(1);
      ce_n = 1'b1;
      we_n = 1'b1;
      cs = 1'b0;
      lk(12);
      // port roles must be unchanged once the write cycle has closed
      chk({62'h0, oe1, oe2}, dir ? 64'h1 : 64'h2, "port roles after write");
   endtask
   // read cycle; fl floats the port for the first byte only
   task automatic rd(input logic [17:0] a, input logic [63:0] e, input logic fl);
      oe_n = fl;
      addr = a;
      cs = 1'b1;
      ce_n = 1'b0;
      lk(1);
      addr = ~a;
      lk(10);
      ce_n = 1'b1;
      cs = 1'b0;
      rs_n = 1'b0;
      lk(1);
      rs_n = 1'b1;
      lk(1);
      for (int i = 0; i < 9; i++) begin
         soc = 1'b1;
         lk(2);
         if (fl && i == 0) chk({62'h0, oe1, oe2}, 64'h0, "floated port");
         else chk({56'h0, dir ? p2_o : p1_o}, (i < 8) ? {56'h0, e[63-8*i -: 8]} : 64'h0, "byte");
         soc = 1'b0;
         lk(1);
         if (fl && i == 0) begin
            oe_n = 1'b0;
            lk(4);
         end
         else chk({56'h0, dir ? p2_o : p1_o}, (i < 8) ? {56'h0, e[63-8*i -: 8]} : 64'h0, "held");
      end
   endtask
   // enable, float and forced low on the one direction given by d
   task automatic outctl(input logic d);
      dir = d;
      oe_n = 1'b1;
      // long enough for the eight-cycle float check to fire
      lk(9);
      chk({62'h0, oe1, oe2}, 64'h0, "float");
      oe_n = 1'b0;
      lk(5);
      chk({62'h0, oe1, oe2}, d ? 64'h1 : 64'h2, "enable");
      frc = 1'b1;
      // long enough for the eight-cycle forced-low check to fire
      lk(9);
      chk({55'h0, oe1 | oe2, d ? p2_o : p1_o}, 64'h100, "forced low");
      frc = 1'b0;
      lk(5);
      chk({62'h0, oe1, oe2}, d ? 64'h1 : 64'h2, "released");
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      // link side needs four of its own edges of reset, longer than two core cycles
      lk(4);
      rst = 1'b0;
      lk(4);
      outctl(1'b1);
      outctl(1'b0);
      wr(18'h00200, 1'b1, 64'h0123456789abcdef);
      rd(18'h00200, 64'h0123456789abcdef, 1'b0);
      dir = 1'b1;
      wr(18'h29f0d, 1'b1, 64'hfedcba9876543210);
      rd(18'h29f0d, 64'hfedcba9876543210, 1'b1);
      wr(18'h0010e, 1'b1, 64'h5a5a5a5a5a5a5a5a);
      wr(18'h2a000, 1'b1, 64'h3c3c3c3c3c3c3c3c);
      wr(18'h00200, 1'b0, 64'h5a5a5a5a5a5a5a5a);
      rd(18'h00200, 64'h0123456789abcdef, 1'b0);
      rd(18'h29f0d, 64'hfedcba9876543210, 1'b0);
      results;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      $display("ERROR %0t: run did not finish", $time);
      results;
   end
endmodule
